// >>> fbp_defines.svh
// Constants for the flash block protection and timing controller
`ifndef FBP_DEFINES_SVH
`define FBP_DEFINES_SVH

`define FBP_USEC_RST    8'h18
`define FBP_POL_RST     64'hffffffffffffffff
`define FBP_POL_W       32
`define FBP_POL_REGS    2
`define FBP_POL_IDX_W   5
`define FBP_ERASE_SHIFT 8
`define FBP_UNIT_SHIFT  9
`define FBP_ERASE_LAST  8'hff
`define FBP_ERASED      32'hffffffff
`define FBP_RD_BLOCKED  32'h00000000
`define FBP_PROG_US     16'h0014
`define FBP_ERASE_US    16'h2710

`endif

// >>> fbp_pkg.sv
// Types shared by the flash block protection controller
package fbp_pkg;

  typedef enum logic [1:0] {
    FBP_CMD_NONE  = 2'b00,
    FBP_CMD_PROG  = 2'b01,
    FBP_CMD_ERASE = 2'b10
  } fbp_cmd_e;

  typedef enum logic [1:0] {
    FBP_ST_IDLE  = 2'b00,
    FBP_ST_PROG  = 2'b01,
    FBP_ST_EWAIT = 2'b10,
    FBP_ST_EFILL = 2'b11
  } fbp_state_e;

  typedef struct packed {
    fbp_cmd_e    cmd;
    logic [31:0] addr;
    logic [31:0] data;
  } fbp_op_s;

  typedef struct packed {
    logic       is_prog;
    logic       idx;
  } fbp_sel_s;

  typedef struct packed {
    logic [63:0] block_read_permit;
    logic [63:0] block_program_permit;
  } fbp_policy_s;

  typedef struct packed {
    logic prog_blocked;
    logic read_blocked;
  } fbp_viol_s;

endpackage

// >>> fbp_ctrl.sv
// Flash array with per-unit read/program protection and microsecond timing
`timescale 1ns/1ps
`include "fbp_defines.svh"

module fbp_ctrl
  import fbp_pkg::*;
#(
  parameter int          FLASH_WORDS = 32768,
  parameter int          AW          = 15,
  parameter logic [15:0] PROG_US     = `FBP_PROG_US,
  parameter logic [15:0] ERASE_US    = `FBP_ERASE_US
) (
  input  wire logic        SYS_CLK,      // System clock
  input  wire logic        SYS_RST,      // Power-on reset
  input  wire logic        CLK_EN,       // Freezes state when low
  input  wire logic        FACTORY_RST,  // Loads factory policy
  input  wire logic        POL_WR,       // Policy write strobe
  input  wire logic        POL_COMMIT,   // Policy commit strobe
  input  wire fbp_sel_s    POL_SEL,      // Policy register select
  input  wire logic [31:0] POL_WDATA,    // Policy write data
  output fbp_policy_s      POLICY,       // Active policy
  input  wire logic        USEC_WR,      // Reload write strobe
  input  wire logic [7:0]  USEC_WDATA,   // Reload write data
  output logic [7:0]       MICROSECOND_RELOAD, // Cycles per us minus 1
  input  wire logic        OP_REQ,       // Program/erase request
  input  wire fbp_op_s     OP,           // Command, address, data
  output logic             OP_READY,     // Accepts a request
  output logic             OP_DONE,      // Operation finished
  input  wire logic        RD_REQ,       // Read request
  input  wire logic        RD_FETCH,     // Instruction fetch
  input  wire logic [31:0] RD_ADDR,      // Read word address
  output logic [31:0]      RD_DATA,      // Read data
  output logic             RD_VALID,     // Read data valid
  input  wire logic        ACCESS_VIOLATION_IRQ_MASK, // Program irq mask
  input  wire logic        READ_VIOL_IRQ_MASK,        // Read irq mask
  output fbp_viol_s        VIOL,         // Violation pulses
  output logic             FLASH_IRQ     // Controller interrupt
);

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic [5:0] unit_of(input logic [31:0] a);
    unit_of = a[`FBP_UNIT_SHIFT +: 6];
  endfunction

  function automatic logic permit(input logic [63:0] v, input logic [31:0] a);
    logic [5:0] u;
    u = unit_of(a);
    permit = v[{u[5], u[4:0]}];
  endfunction

  logic [31:0]  mem [FLASH_WORDS];
  logic [63:0]  rd_vol_q;
  logic [63:0]  pg_vol_q;
  logic [63:0]  rd_nv_q;
  logic [63:0]  pg_nv_q;
  logic [7:0]   reload_q;
  logic [7:0]   us_cnt_q;
  logic         us_tick;
  logic [15:0]  timer_q;
  fbp_state_e   state_q;
  logic [31:0]  addr_q;
  logic [31:0]  data_q;
  logic [7:0]   fill_q;
  logic         done_q;
  fbp_viol_s    viol_q;
  logic         irq_q;
  logic [31:0]  rd_data_q;
  logic         rd_valid_q;
  logic         start_ok;
  logic         start_bad;
  logic         rd_bad;
  logic         prog_wr;
  logic [AW-1:0] erase_word;
  logic [31:0]  cur_word;

  // ----------------------------------------------------------------
  // Protection policy
  // ----------------------------------------------------------------
  // Volatile copy is what the access checks use
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rd_vol_q <= rd_nv_q;
      pg_vol_q <= pg_nv_q;
    end else if (CLK_EN && POL_WR) begin
      for (int i = 0; i < `FBP_POL_REGS; i++) begin
        if (POL_SEL.idx == i[0]) begin
          if (POL_SEL.is_prog) begin
            pg_vol_q[i*`FBP_POL_W +: `FBP_POL_W] <=
              POL_WDATA & pg_nv_q[i*`FBP_POL_W +: `FBP_POL_W];
          end else begin
            rd_vol_q[i*`FBP_POL_W +: `FBP_POL_W] <=
              POL_WDATA & rd_nv_q[i*`FBP_POL_W +: `FBP_POL_W];
          end
        end
      end
    end
  end

  // Nonvolatile copy survives SYS_RST; only the factory load sets ones
  always_ff @(posedge SYS_CLK) begin
    if (FACTORY_RST) begin
      rd_nv_q <= `FBP_POL_RST;
      pg_nv_q <= `FBP_POL_RST;
    end else if (CLK_EN && POL_COMMIT) begin
      for (int i = 0; i < `FBP_POL_REGS; i++) begin
        if (POL_SEL.idx == i[0]) begin
          if (POL_SEL.is_prog) begin
            pg_nv_q[i*`FBP_POL_W +: `FBP_POL_W] <=
              pg_nv_q[i*`FBP_POL_W +: `FBP_POL_W] & pg_vol_q[i*`FBP_POL_W +: `FBP_POL_W];
          end else begin
            rd_nv_q[i*`FBP_POL_W +: `FBP_POL_W] <=
              rd_nv_q[i*`FBP_POL_W +: `FBP_POL_W] & rd_vol_q[i*`FBP_POL_W +: `FBP_POL_W];
          end
        end
      end
    end
  end

  assign POLICY.block_read_permit    = rd_vol_q;
  assign POLICY.block_program_permit = pg_vol_q;

  // ----------------------------------------------------------------
  // Microsecond timebase
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      reload_q <= `FBP_USEC_RST;
    end else if (CLK_EN && USEC_WR) begin
      reload_q <= USEC_WDATA;
    end
  end

  // Restarted per operation so the first microsecond is full length
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      us_cnt_q <= `FBP_USEC_RST;
    end else if (CLK_EN) begin
      if (start_ok || us_tick) begin
        us_cnt_q <= reload_q;
      end else begin
        us_cnt_q <= us_cnt_q - 8'h01;
      end
    end
  end

  assign us_tick = (us_cnt_q == 8'h00);
  assign MICROSECOND_RELOAD = reload_q;

  // ----------------------------------------------------------------
  // Program and erase sequencer
  // ----------------------------------------------------------------
  assign OP_READY  = (state_q == FBP_ST_IDLE);
  assign start_bad = OP_READY && OP_REQ && OP.cmd != FBP_CMD_NONE &&
                     !permit(pg_vol_q, OP.addr);
  assign start_ok  = OP_READY && OP_REQ && OP.cmd != FBP_CMD_NONE &&
                     permit(pg_vol_q, OP.addr);
  assign prog_wr   = (state_q == FBP_ST_PROG) && us_tick && timer_q == 16'h0000;
  assign erase_word = AW'({addr_q[AW-1:`FBP_ERASE_SHIFT], fill_q});
  assign cur_word  = mem[addr_q[AW-1:0]];

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_q <= FBP_ST_IDLE;
      timer_q <= 16'h0000;
      addr_q  <= 32'h00000000;
      data_q  <= 32'h00000000;
      fill_q  <= 8'h00;
    end else if (CLK_EN) begin
      case (state_q)
        FBP_ST_IDLE: begin
          if (start_ok) begin
            addr_q <= OP.addr;
            data_q <= OP.data;
            fill_q <= 8'h00;
            if (OP.cmd == FBP_CMD_PROG) begin
              timer_q <= PROG_US;
              state_q <= FBP_ST_PROG;
            end else begin
              timer_q <= ERASE_US;
              state_q <= FBP_ST_EWAIT;
            end
          end
        end
        FBP_ST_PROG: begin
          if (us_tick) begin
            if (timer_q == 16'h0000) begin
              state_q <= FBP_ST_IDLE;
            end else begin
              timer_q <= timer_q - 16'h0001;
            end
          end
        end
        FBP_ST_EWAIT: begin
          if (us_tick) begin
            if (timer_q == 16'h0000) begin
              state_q <= FBP_ST_EFILL;
            end else begin
              timer_q <= timer_q - 16'h0001;
            end
          end
        end
        FBP_ST_EFILL: begin
          fill_q <= fill_q + 8'h01;
          if (fill_q == `FBP_ERASE_LAST) begin
            state_q <= FBP_ST_IDLE;
          end
        end
        default: begin
          state_q <= FBP_ST_IDLE;
        end
      endcase
    end
  end

  // Array has no reset; its contents model the nonvolatile cells
  always_ff @(posedge SYS_CLK) begin
    if (!SYS_RST && CLK_EN) begin
      if (prog_wr) begin
        mem[addr_q[AW-1:0]] <= cur_word & data_q;
      end else if (state_q == FBP_ST_EFILL) begin
        mem[erase_word] <= `FBP_ERASED;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      done_q <= 1'b0;
    end else if (CLK_EN) begin
      done_q <= start_bad || prog_wr ||
                (state_q == FBP_ST_EFILL && fill_q == `FBP_ERASE_LAST);
    end
  end

  assign OP_DONE = done_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Fetches bypass the read permit; debugger reads count as data reads
  assign rd_bad = RD_REQ && !RD_FETCH && !permit(rd_vol_q, RD_ADDR);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rd_data_q  <= 32'h00000000;
      rd_valid_q <= 1'b0;
    end else if (CLK_EN) begin
      rd_valid_q <= RD_REQ;
      if (rd_bad) begin
        rd_data_q <= `FBP_RD_BLOCKED;
      end else if (RD_REQ) begin
        rd_data_q <= mem[RD_ADDR[AW-1:0]];
      end
    end
  end

  assign RD_DATA  = rd_data_q;
  assign RD_VALID = rd_valid_q;

  // ----------------------------------------------------------------
  // Violation reporting
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      viol_q <= '0;
      irq_q  <= 1'b0;
    end else if (CLK_EN) begin
      viol_q.prog_blocked <= start_bad;
      viol_q.read_blocked <= rd_bad;
      irq_q <= (start_bad && ACCESS_VIOLATION_IRQ_MASK) ||
               (rd_bad && READ_VIOL_IRQ_MASK);
    end
  end

  assign VIOL      = viol_q;
  assign FLASH_IRQ = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  a_erase_fill_ones:
    assert property (CLK_EN && state_q == FBP_ST_EFILL |=> mem[$past(erase_word)] == `FBP_ERASED)
    else $error("erase left a zero bit");
  a_prog_clears_only:
    assert property (CLK_EN && prog_wr |=> mem[$past(addr_q[AW-1:0])] == $past(cur_word & data_q))
    else $error("program set a bit");
  a_prog_blocked_idle:
    assert property (CLK_EN && start_bad |=> state_q == FBP_ST_IDLE && VIOL.prog_blocked && OP_DONE)
    else $error("blocked program was started");
  a_read_zero_data:
    assert property (CLK_EN && rd_bad |=> RD_VALID && RD_DATA == 32'h00000000 && VIOL.read_blocked)
    else $error("protected read leaked data");
  a_fetch_not_blocked:
    assert property (CLK_EN && RD_REQ && RD_FETCH |=> RD_VALID && !VIOL.read_blocked)
    else $error("fetch was refused");
  a_irq_mask_gate:
    assert property ($past(CLK_EN) && FLASH_IRQ |->
      (VIOL.prog_blocked && $past(ACCESS_VIOLATION_IRQ_MASK)) ||
      (VIOL.read_blocked && $past(READ_VIOL_IRQ_MASK)))
    else $error("irq without unmasked violation");
  a_reload_reset_val:
    assert property ($past(SYS_RST) |-> MICROSECOND_RELOAD == `FBP_USEC_RST)
    else $error("reload reset value wrong");
  a_nv_one_way:
    assert property (!$past(FACTORY_RST) |->
      (rd_nv_q & ~$past(rd_nv_q)) == 64'h0 && (pg_nv_q & ~$past(pg_nv_q)) == 64'h0)
    else $error("committed bit returned to one");
  a_vol_revert:
    assert property ($past(SYS_RST) |-> rd_vol_q == $past(rd_nv_q) && pg_vol_q == $past(pg_nv_q))
    else $error("policy not restored at reset");
  a_tick_period:
    assert property (CLK_EN && start_ok |=> us_cnt_q == $past(reload_q))
    else $error("timebase not reloaded");

endmodule

// >>> fbp_cpu_model.sv
// Core-side model issuing program, erase and read requests
`timescale 1ns/1ps

module fbp_cpu_model
  import fbp_pkg::*;
(
  input  wire logic        clk,      // System clock
  output fbp_op_s          op,       // Command, address, data
  output logic             op_req,   // Program/erase request
  input  wire logic        op_ready, // Accepts a request
  input  wire logic        op_done,  // Operation finished
  output logic             rd_req,   // Read request
  output logic             rd_fetch, // Instruction fetch
  output logic [31:0]      rd_addr,  // Read word address
  input  wire logic [31:0] rd_data,  // Read data
  input  wire logic        rd_valid, // Read data valid
  input  wire fbp_viol_s   viol,     // Violation pulses
  input  wire logic        irq       // Controller interrupt
);
  fbp_viol_s   viol_q;
  logic        irq_q;
  logic        rdy_q;
  logic [31:0] data_q;
  int          cyc_q;

  initial begin
    op = '0;
    op_req = 1'b0;
    rd_req = 1'b0;
    rd_fetch = 1'b0;
    rd_addr = '0;
  end

  // ------
  // Bus cycles
  // ------
  // Released command goes to none and the other fields show the inverse, so a stale value never looks valid
  task automatic send_op(input fbp_cmd_e c, input logic [31:0] ad, input logic [31:0] d);
    @(posedge clk);
    op_req <= 1'b1;
    op <= '{c, ad, d};
    // Request stands until an edge that sees the sequencer idle
    #1;
    while (op_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    op_req <= 1'b0;
    op <= '{FBP_CMD_NONE, ~ad, ~d};
    cyc_q = 0;
    #1;
    rdy_q = op_ready;
    while (op_done !== 1'b1 && cyc_q < 4000) begin
      @(posedge clk);
      #1;
      cyc_q++;
    end
    viol_q = viol;
    irq_q = irq;
  endtask

  task automatic read(input logic f, input logic [31:0] ad);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_fetch <= f;
    rd_addr <= ad;
    @(posedge clk);
    rd_req <= 1'b0;
    rd_fetch <= ~f;
    rd_addr <= ~ad;
    cyc_q = 0;
    #1;
    while (rd_valid !== 1'b1 && cyc_q < 4) begin
      @(posedge clk);
      #1;
      cyc_q++;
    end
    data_q = rd_data;
    viol_q = viol;
    irq_q = irq;
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the flash protection controller
`timescale 1ns/1ps

module tb_top
  import fbp_pkg::*;
;
  logic        SYS_CLK, SYS_RST, FACTORY_RST, POL_WR, POL_COMMIT, USEC_WR;
  logic        OP_REQ, OP_READY, OP_DONE, RD_REQ, RD_FETCH, RD_VALID;
  logic        AV_MASK, RD_MASK, FLASH_IRQ, CLK_EN;
  logic [7:0]  USEC_WDATA, MICROSECOND_RELOAD, m_rel;
  logic [31:0] POL_WDATA, RD_ADDR, RD_DATA, a;
  fbp_sel_s    POL_SEL;
  fbp_policy_s POLICY;
  fbp_op_s     OP;
  fbp_viol_s   VIOL;
  int          err_total, n_tests;
  int          cycles = 0;
  logic [31:0] mem [int];
  logic [31:0] vol [2][2];
  logic [31:0] nv [2][2];
  logic [7:0]  rl [2] = '{8'h0f, 8'h09};
  int          ub [4] = '{0, 256, 512, 16896};
  int          un [2] = '{33, 1};

  fbp_ctrl #(.PROG_US(16'h0002), .ERASE_US(16'h0003)) u_fbp_ctrl (
    .SYS_CLK, .SYS_RST, .CLK_EN, .FACTORY_RST, .POL_WR, .POL_COMMIT, .POL_SEL,
    .POL_WDATA, .POLICY, .USEC_WR, .USEC_WDATA, .MICROSECOND_RELOAD, .OP_REQ, .OP,
    .OP_READY, .OP_DONE, .RD_REQ, .RD_FETCH, .RD_ADDR, .RD_DATA, .RD_VALID,
    .ACCESS_VIOLATION_IRQ_MASK(AV_MASK), .READ_VIOL_IRQ_MASK(RD_MASK), .VIOL, .FLASH_IRQ);

  fbp_cpu_model u_fbp_cpu_model (.clk(SYS_CLK), .op(OP), .op_req(OP_REQ),
    .op_ready(OP_READY), .op_done(OP_DONE), .rd_req(RD_REQ), .rd_fetch(RD_FETCH),
    .rd_addr(RD_ADDR), .rd_data(RD_DATA), .rd_valid(RD_VALID), .viol(VIOL), .irq(FLASH_IRQ));

  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end

  // Erase of a whole block costs about 300 cycles at the reload of 9 used here, so this leaves wide margin
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      finish_test();
    end
  end

  // ------
  // Model and checks
  // ------
  task automatic finish_test();
    $display("Summary: %0d mismatches in %0d comparisons", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic ok(input logic p, input logic [31:0] ad);
    logic [5:0] u;
    u = ad[14:9];
    return vol[p][u[5]][u[4:0]];
  endfunction

  task automatic pchk();
    chk(POLICY.block_read_permit, {vol[0][1], vol[0][0]});
    chk(POLICY.block_program_permit, {vol[1][1], vol[1][0]});
  endtask

  task automatic pol(input logic p, input logic i, input logic [31:0] d, input logic cm);
    @(posedge SYS_CLK);
    POL_SEL <= '{p, i};
    POL_WDATA <= d;
    POL_WR <= !cm;
    POL_COMMIT <= cm;
    @(posedge SYS_CLK);
    POL_WR <= 1'b0;
    POL_COMMIT <= 1'b0;
    if (cm) nv[p][i] = nv[p][i] & vol[p][i];
    else vol[p][i] = d & nv[p][i];
    #1;
    pchk();
  endtask

  task automatic op(input fbp_cmd_e c, input logic [31:0] ad, input logic [31:0] d);
    logic b;
    b = !ok(1'b1, ad);
    u_fbp_cpu_model.send_op(c, ad, d);
    chk(u_fbp_cpu_model.viol_q.prog_blocked, b);
    chk(u_fbp_cpu_model.irq_q, b & AV_MASK);
    chk(u_fbp_cpu_model.rdy_q, b);
    // Program waits 3 ticks, erase 4 ticks then 256 fill cycles (PROG_US 2, ERASE_US 3)
    if (b) chk(u_fbp_cpu_model.cyc_q, 0);
    else if (c == FBP_CMD_PROG) begin
      chk(u_fbp_cpu_model.cyc_q, 3 * (m_rel + 1));
      mem[ad] = mem[ad] & d;
    end else begin
      chk(u_fbp_cpu_model.cyc_q, 4 * (m_rel + 1) + 256);
      for (int i = 0; i < 256; i++) mem[{ad[31:8], 8'h00} + i] = 32'hffffffff;
    end
  endtask

  task automatic rd(input logic f, input logic [31:0] ad);
    logic b;
    b = !f && !ok(1'b0, ad);
    u_fbp_cpu_model.read(f, ad);
    chk(u_fbp_cpu_model.cyc_q, 0);
    chk(u_fbp_cpu_model.data_q, b ? 32'h0 : mem[ad]);
    chk(u_fbp_cpu_model.viol_q.read_blocked, b);
    chk(u_fbp_cpu_model.irq_q, b & RD_MASK);
  endtask

  // ------
  // Stimulus
  // ------
  initial begin
    SYS_RST = 1'b1;
    FACTORY_RST = 1'b1;
    POL_WR = 1'b0;
    POL_COMMIT = 1'b0;
    POL_SEL = '0;
    POL_WDATA = '0;
    USEC_WR = 1'b0;
    USEC_WDATA = '0;
    AV_MASK = 1'b0;
    RD_MASK = 1'b0;
    CLK_EN = 1'b1;
    err_total = 0;
    n_tests = 0;
    foreach (nv[p, i]) nv[p][i] = 32'hffffffff;
    vol = nv;
    m_rel = 8'h18;
    void'($urandom(32'h892f));
    repeat (8) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    FACTORY_RST <= 1'b0;
    #1;
    pchk();
    chk(MICROSECOND_RELOAD, m_rel);
    foreach (rl[k]) begin
      @(posedge SYS_CLK);
      USEC_WR <= 1'b1;
      USEC_WDATA <= rl[k];
      @(posedge SYS_CLK);
      USEC_WR <= 1'b0;
      m_rel = rl[k];
      #1;
      chk(MICROSECOND_RELOAD, m_rel);
    end
    // A write while the enable is low must be lost
    @(posedge SYS_CLK);
    CLK_EN <= 1'b0;
    USEC_WR <= 1'b1;
    USEC_WDATA <= 8'($urandom);
    @(posedge SYS_CLK);
    CLK_EN <= 1'b1;
    USEC_WR <= 1'b0;
    #1;
    chk(MICROSECOND_RELOAD, m_rel);
    foreach (ub[k]) op(FBP_CMD_ERASE, ub[k], $urandom);
    repeat (4) rd(1'b0, $urandom % 512);
    a = $urandom % 256;
    repeat (2) op(FBP_CMD_PROG, a, $urandom);
    rd(1'b0, a);
    foreach (un[k]) begin
      pol(1'b1, un[k] > 31, ~(32'h1 << (un[k] % 32)), 1'b0);
      for (int m = 0; m < 2; m++) begin
        @(posedge SYS_CLK);
        AV_MASK <= m[0];
        op(FBP_CMD_PROG, un[k] * 512 + 5, 32'h0);
        op(FBP_CMD_ERASE, un[k] * 512, 32'h0);
      end
      op(FBP_CMD_PROG, 518, $urandom);
      rd(1'b0, un[k] * 512 + 5);
    end
    pol(1'b0, 1'b0, 32'hfffffffe, 1'b0);
    op(FBP_CMD_PROG, a + 1, $urandom);
    for (int m = 0; m < 2; m++) begin
      @(posedge SYS_CLK);
      RD_MASK <= m[0];
      rd(1'b0, a + 1);
      rd(1'b1, a + 1);
    end
    pol(1'b0, 1'b0, 32'hfffffffe, 1'b1);
    pol(1'b0, 1'b0, 32'hffffffff, 1'b0);
    @(posedge SYS_CLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    vol = nv;
    m_rel = 8'h18;
    #1;
    pchk();
    chk(MICROSECOND_RELOAD, m_rel);
    op(FBP_CMD_PROG, 519, $urandom);
    rd(1'b0, a + 1);
    finish_test();
  end
endmodule
